// File: design/mds_supervisor.v
// Function
// [RL1] nonzero jerk: ramp passes a lag filter, time constant decel over jerk
// [RL2] guard threshold below envelope: envelope is the limit, guard flags error
// [RL3] envelope at selected window: actual velocity must stay below window
// [RL4] end early when velocity inside selected window and drive enable gone
// [RL5] end early when envelope reached window and direction monitoring fits
// [RL6] host reports done by raising done signal; device then ends transition
// [RL7] done edge counts only after at least 10 ms low
// [RL8] done edge before target velocity reached: raise F7052 and decelerate
// [RL9] immediate option from normal operation switches straight to motion mode
// [RL10] immediate option within motion mode switches function to function
// [RL11] safety fault: error deceleration, ignore host, brake, then drop enable
// [RL12] error deceleration: two-channel envelope from velocity plus tolerance
// [RL13] envelope left: keep braking, F7051 or F8351 by class and equality
// [RL14] transition time exceeded: keep braking, F7050 or F8350 likewise
// [RL15] error envelope at standstill window: velocity must stay below it
// [RL16] error transition ends once enable gone and velocity below window
// [RL17] immediate switching enabled separately for both change kinds
// [RL18] immediate only with velocity in window and direction monitoring fitting
// [RL19] normal envelope starts at actual velocity plus deceleration tolerance
// [RL20] either channel outside envelope raises the envelope error
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`include "mds_consts.vh"
`default_nettype none
module mds_supervisor #(
	parameter VW = 16,
	parameter DONE_LOW_CYC = `MDS_DONE_LOW_MS * `MDS_CLK_KHZ,
	parameter ENV_TICK_CYC = `MDS_ENV_TICK_MS * `MDS_CLK_KHZ
) (
	input wire pclk, // apb clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output wire pready, // apb ready
	output wire pslverr, // apb error
	input wire [VW-1:0] vel_a, // actual speed magnitude, channel a
	input wire [VW-1:0] vel_b, // actual speed magnitude, channel b
	input wire drive_enable, // drive enable currently applied
	input wire transition_done, // host done signal
	input wire safety_fault, // safety error or warning level
	output reg cmd_ignore, // drive ignores host command values
	output reg brake_req, // drive brakes by stopping setup
	output reg enable_withdraw, // request to remove drive enable
	output reg switch_pulse, // one cycle: selected function now active
	output reg safe_stop, // safe standstill error state
	output reg [VW-1:0] active_limit // active speed threshold
);
	localparam S_IDLE = 3'd0;
	localparam S_RAMP = 3'd1;
	localparam S_HOLD = 3'd2;
	localparam S_STOP = 3'd3;
	// ==========================================================
	// register file
	reg [31:0] ctrl, ttime, e_ttime, guard_max, guard_lim;
	reg [VW-1:0] decel, jerk, tol, sel_win, e_decel, e_jerk, e_tol, still_win;
	reg [4:0] flags;
	reg [15:0] err_code;
	reg [2:0] state;
	reg err_mode;
	reg done_seen;
	reg [VW-1:0] env, ramp;
	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite;
	wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `MDS_REG_ENVELOPE);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	wire go = wr & mapped & (paddr == `MDS_REG_CTRL) & pwdata[`MDS_CTRL_GO];
	wire ack = wr & mapped & (paddr == `MDS_REG_CTRL) & pwdata[`MDS_CTRL_ACK];
	wire st_wr = wr & mapped & (paddr == `MDS_REG_STATUS);
	reg [4:0] set_flags;
	reg [31:0] rd;
	always @*
	begin
		case (paddr)
		`MDS_REG_CTRL: rd = ctrl;
		`MDS_REG_DECEL: rd = {{(32-VW){1'b0}}, decel};
		`MDS_REG_JERK: rd = {{(32-VW){1'b0}}, jerk};
		`MDS_REG_TOL: rd = {{(32-VW){1'b0}}, tol};
		`MDS_REG_SEL_WIN: rd = {{(32-VW){1'b0}}, sel_win};
		`MDS_REG_TTIME: rd = ttime;
		`MDS_REG_E_DECEL: rd = {{(32-VW){1'b0}}, e_decel};
		`MDS_REG_E_JERK: rd = {{(32-VW){1'b0}}, e_jerk};
		`MDS_REG_E_TOL: rd = {{(32-VW){1'b0}}, e_tol};
		`MDS_REG_STILL_WIN: rd = {{(32-VW){1'b0}}, still_win};
		`MDS_REG_E_TTIME: rd = e_ttime;
		`MDS_REG_GUARD_MAX: rd = guard_max;
		`MDS_REG_GUARD_LIM: rd = guard_lim;
		`MDS_REG_STATUS: rd = {19'h00000, done_seen, err_mode, state,
			3'h0, flags};
		`MDS_REG_ERRCODE: rd = {16'h0000, err_code};
		`MDS_REG_ENVELOPE: rd = {{(32-VW){1'b0}}, env};
		default: rd = 32'h00000000;
		endcase
	end
	// read data captured in the setup cycle, so zero-wait access is safe
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (setup)
			prdata <= rd;
	end
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= `MDS_RST_CTRL;
			decel <= `MDS_RST_VEL;
			jerk <= `MDS_RST_VEL;
			tol <= `MDS_RST_VEL;
			sel_win <= `MDS_RST_VEL;
			ttime <= `MDS_RST_TTIME;
			e_decel <= `MDS_RST_VEL;
			e_jerk <= `MDS_RST_VEL;
			e_tol <= `MDS_RST_VEL;
			still_win <= `MDS_RST_VEL;
			e_ttime <= `MDS_RST_TTIME;
			guard_max <= 32'h00000000;
			guard_lim <= 32'h00000000;
		end
		else if (wr & mapped)
		begin
			case (paddr)
			`MDS_REG_CTRL: ctrl <= pwdata & `MDS_CTRL_MASK;
			`MDS_REG_DECEL: decel <= pwdata[VW-1:0];
			`MDS_REG_JERK: jerk <= pwdata[VW-1:0];
			`MDS_REG_TOL: tol <= pwdata[VW-1:0];
			`MDS_REG_SEL_WIN: sel_win <= pwdata[VW-1:0];
			`MDS_REG_TTIME: ttime <= pwdata;
			`MDS_REG_E_DECEL: e_decel <= pwdata[VW-1:0];
			`MDS_REG_E_JERK: e_jerk <= pwdata[VW-1:0];
			`MDS_REG_E_TOL: e_tol <= pwdata[VW-1:0];
			`MDS_REG_STILL_WIN: still_win <= pwdata[VW-1:0];
			`MDS_REG_E_TTIME: e_ttime <= pwdata;
			`MDS_REG_GUARD_MAX: guard_max <= pwdata;
			`MDS_REG_GUARD_LIM: guard_lim <= pwdata;
			default: ;
			endcase
		end
	end
	// ==========================================================
	// two-channel comparisons
	wire [VW-1:0] vmax = (vel_a > vel_b) ? vel_a : vel_b;
	wire [VW-1:0] win = err_mode ? still_win : sel_win;
	wire env_viol = (vel_a > env) | (vel_b > env); // RL20
	wire win_viol = (vel_a >= win) | (vel_b >= win);
	wire in_sel = (vel_a < sel_win) & (vel_b < sel_win);
	wire in_win = ~win_viol;
	wire dir_ok = (ctrl[`MDS_CTRL_SEL_DIR] == 2'b00) |
		(ctrl[`MDS_CTRL_SEL_DIR] == ctrl[`MDS_CTRL_ACT_DIR]);
	wire imm_on = ctrl[`MDS_CTRL_FROM_MM] ? ctrl[`MDS_CTRL_IMM_MM] :
		ctrl[`MDS_CTRL_IMM_NO]; // RL17
	wire imm_ok = imm_on & in_sel & dir_ok; // RL18
	wire hi_code = ctrl[`MDS_CTRL_UPPER] | ctrl[`MDS_CTRL_EQUAL];
	// ==========================================================
	// done-edge qualifier
	reg done_q;
	reg [31:0] low_cnt;
	wire low_ok = (low_cnt >= DONE_LOW_CYC);
	wire done_edge = transition_done & ~done_q & low_ok; // RL7
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_q <= 1'b1;
			low_cnt <= 32'h00000000;
		end
		else
		begin
			done_q <= transition_done;
			if (transition_done)
				low_cnt <= 32'h00000000;
			else if (!low_ok)
				low_cnt <= low_cnt + 32'h00000001;
		end
	end
	// ==========================================================
	// envelope generator with lag filter on the ramp
	reg [31:0] tick_cnt;
	wire tick = (tick_cnt == ENV_TICK_CYC - 1);
	wire [VW-1:0] cur_decel = err_mode ? e_decel : decel;
	wire [VW-1:0] cur_jerk = err_mode ? e_jerk : jerk;
	wire [VW:0] start_sum = {1'b0, vmax} + {1'b0, err_mode ? e_tol : tol};
	wire [VW-1:0] start_val = start_sum[VW] ? {VW{1'b1}} : start_sum[VW-1:0];
	wire [VW-1:0] ramp_next = (ramp > cur_decel) ? ramp - cur_decel :
		{VW{1'b0}};
	reg div_busy;
	reg [5:0] div_cnt;
	reg [31:0] div_num;
	reg [VW:0] div_rem;
	reg [VW-1:0] div_gap;
	wire [VW:0] rem_sh = {div_rem[VW-1:0], div_num[31]};
	wire rem_ge = (rem_sh >= {1'b0, cur_decel});
	wire [VW:0] rem_new = rem_ge ? rem_sh - {1'b0, cur_decel} : rem_sh;
	wire [VW-1:0] gap_now = env - ramp_next;
	wire [2*VW-1:0] gap_prod = gap_now * cur_jerk;
	wire [VW-1:0] step = (div_num > {{(32-VW){1'b0}}, div_gap}) ? div_gap :
		div_num[VW-1:0];
	reg load_env;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt <= 32'h00000000;
			env <= {VW{1'b1}};
			ramp <= {VW{1'b1}};
			div_busy <= 1'b0;
			div_cnt <= 6'h00;
			div_num <= 32'h00000000;
			div_rem <= {(VW+1){1'b0}};
			div_gap <= {VW{1'b0}};
		end
		else if (load_env)
		begin
			tick_cnt <= 32'h00000000;
			env <= start_val; // RL19 RL12
			ramp <= start_val;
			div_busy <= 1'b0;
		end
		else if (state == S_RAMP || state == S_HOLD)
		begin
			tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
			if (tick)
			begin
				ramp <= ramp_next;
				if (cur_jerk == {VW{1'b0}} || cur_decel == {VW{1'b0}})
					env <= ramp_next;
				else
				begin
					// step = gap * jerk / decel, i.e. tick / time constant
					div_busy <= 1'b1; // RL1
					div_cnt <= 6'h00;
					div_num <= gap_prod[31:0];
					div_rem <= {(VW+1){1'b0}};
					div_gap <= gap_now;
				end
			end
			else if (div_busy)
			begin
				div_rem <= rem_new;
				div_num <= {div_num[30:0], rem_ge};
				div_cnt <= div_cnt + 6'h01;
				if (div_cnt == 6'd32)
				begin
					div_busy <= 1'b0;
					env <= env - step; // RL1
				end
			end
		end
		else
			tick_cnt <= 32'h00000000;
	end
	// ==========================================================
	// guards and active threshold
	wire max_on = guard_max[`MDS_GUARD_ON];
	wire lim_on = guard_lim[`MDS_GUARD_ON];
	wire trans = (state == S_RAMP) | (state == S_HOLD);
	wire [VW-1:0] max_thr = (trans && guard_max[VW-1:0] < env) ? env :
		guard_max[VW-1:0]; // RL2
	wire [VW-1:0] lim_thr = (trans && guard_lim[VW-1:0] < env) ? env :
		guard_lim[VW-1:0]; // RL2
	wire max_viol = max_on & ((vel_a > max_thr) | (vel_b > max_thr));
	wire lim_viol = lim_on & ((vel_a > lim_thr) | (vel_b > lim_thr));
	// ==========================================================
	// transition sequencer
	reg [31:0] tmr;
	reg tmr_fired;
	reg [2:0] next_state;
	reg next_err_mode;
	reg [15:0] next_code;
	reg end_ok;
	always @*
	begin
		next_state = state;
		next_err_mode = err_mode;
		next_code = err_code;
		set_flags = 5'h00;
		load_env = 1'b0;
		end_ok = 1'b0;
		if (max_viol)
			set_flags[`MDS_ST_MAX_ERR] = 1'b1; // RL2
		if (lim_viol)
			set_flags[`MDS_ST_LIM_ERR] = 1'b1; // RL2
		case (state)
		S_IDLE:
		begin
			if (safety_fault)
			begin
				next_err_mode = 1'b1; // RL11
				load_env = 1'b1;
				next_state = S_RAMP;
			end
			else if (go && imm_ok)
				end_ok = 1'b1; // RL9 RL10
			else if (go)
			begin
				load_env = 1'b1;
				next_state = S_RAMP;
			end
		end
		S_RAMP, S_HOLD:
		begin
			if (state == S_RAMP && env <= win)
				next_state = S_HOLD;
			if ((state == S_RAMP && env_viol) ||
				(state == S_HOLD && win_viol))
			begin
				set_flags[`MDS_ST_ENV_ERR] = 1'b1; // RL3 RL15 RL20
				next_code = hi_code ? `MDS_ERR_ENV_HI :
					`MDS_ERR_ENV_LO; // RL13
			end
			if (tmr_fired)
			begin
				set_flags[`MDS_ST_TIME_ERR] = 1'b1;
				next_code = hi_code ? `MDS_ERR_TIME_HI :
					`MDS_ERR_TIME_LO; // RL14
			end
			if (err_mode)
			begin
				if (!drive_enable && in_win)
					next_state = S_STOP; // RL16
			end
			else if (safety_fault)
			begin
				// fault during a normal transition restarts as error stop
				next_err_mode = 1'b1; // RL11
				load_env = 1'b1;
				next_state = S_RAMP;
			end
			else if (done_edge && ctrl[`MDS_CTRL_HOST] && !in_sel)
			begin
				set_flags[`MDS_ST_EARLY_ERR] = 1'b1;
				next_code = `MDS_ERR_EARLY; // RL8
				next_err_mode = 1'b1;
				load_env = 1'b1;
				next_state = S_RAMP;
			end
			else if ((in_sel && !drive_enable) || // RL4
				(env <= sel_win && dir_ok) || // RL5
				(done_edge && ctrl[`MDS_CTRL_HOST]) || // RL6
				imm_ok) // RL9 RL10
			begin
				end_ok = 1'b1;
				next_state = S_IDLE;
			end
		end
		S_STOP:
		begin
			if (ack && !safety_fault)
			begin
				next_err_mode = 1'b0;
				next_state = S_IDLE;
			end
		end
		default:
			next_state = S_IDLE;
		endcase
	end
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= S_IDLE;
			err_mode <= 1'b0;
			err_code <= 16'h0000;
			flags <= 5'h00;
			done_seen <= 1'b0;
			tmr <= 32'h00000000;
			tmr_fired <= 1'b0;
		end
		else
		begin
			state <= next_state;
			err_mode <= next_err_mode;
			err_code <= next_code;
			// a new error in the clearing cycle survives the clear
			flags <= (flags & ~(st_wr ? pwdata[4:0] : 5'h00)) | set_flags;
			if (done_edge)
				done_seen <= 1'b1;
			else if (st_wr && pwdata[`MDS_ST_DONE_SEEN])
				done_seen <= 1'b0;
			if (load_env)
			begin
				tmr <= next_err_mode ? e_ttime : ttime; // RL14
				tmr_fired <= 1'b0;
			end
			else if (trans)
			begin
				if (tmr != 32'h00000000)
					tmr <= tmr - 32'h00000001;
				tmr_fired <= (tmr == 32'h00000001);
			end
			else
				tmr_fired <= 1'b0;
		end
	end
	// ==========================================================
	// drive-side outputs
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_ignore <= 1'b0;
			brake_req <= 1'b0;
			enable_withdraw <= 1'b0;
			switch_pulse <= 1'b0;
			safe_stop <= 1'b0;
			active_limit <= {VW{1'b0}};
		end
		else
		begin
			cmd_ignore <= next_err_mode; // RL11
			brake_req <= next_err_mode | ((next_state == S_RAMP ||
				next_state == S_HOLD) && !ctrl[`MDS_CTRL_HOST]);
			// enable dropped once the braked axis is below standstill
			enable_withdraw <= next_err_mode &
				(vel_a < still_win) & (vel_b < still_win); // RL11
			switch_pulse <= end_ok; // RL6
			safe_stop <= (next_state == S_STOP);
			active_limit <= (max_on && (!lim_on || max_thr < lim_thr)) ?
				max_thr : (lim_on ? lim_thr : (trans ? env : {VW{1'b1}}));
		end
	end
endmodule // mds_supervisor
`default_nettype wire

// File: design/mds_consts.vh
`ifndef MDS_CONSTS_VH
`define MDS_CONSTS_VH
// ==========================================================
// register byte offsets
`define MDS_REG_CTRL 8'h00
`define MDS_REG_DECEL 8'h04
`define MDS_REG_JERK 8'h08
`define MDS_REG_TOL 8'h0c
`define MDS_REG_SEL_WIN 8'h10
`define MDS_REG_TTIME 8'h14
`define MDS_REG_E_DECEL 8'h18
`define MDS_REG_E_JERK 8'h1c
`define MDS_REG_E_TOL 8'h20
`define MDS_REG_STILL_WIN 8'h24
`define MDS_REG_E_TTIME 8'h28
`define MDS_REG_GUARD_MAX 8'h2c
`define MDS_REG_GUARD_LIM 8'h30
`define MDS_REG_STATUS 8'h34
`define MDS_REG_ERRCODE 8'h38
`define MDS_REG_ENVELOPE 8'h3c
// ==========================================================
// control register fields
`define MDS_CTRL_GO 0
`define MDS_CTRL_HOST 1
`define MDS_CTRL_IMM_NO 2
`define MDS_CTRL_IMM_MM 3
`define MDS_CTRL_FROM_MM 4
`define MDS_CTRL_UPPER 5
`define MDS_CTRL_EQUAL 6
`define MDS_CTRL_ACK 7
`define MDS_CTRL_ACT_DIR 9:8
`define MDS_CTRL_SEL_DIR 11:10
`define MDS_CTRL_MASK 32'h00000f7e
`define MDS_GUARD_ON 31
// ==========================================================
// status register fields
`define MDS_ST_ENV_ERR 0
`define MDS_ST_TIME_ERR 1
`define MDS_ST_EARLY_ERR 2
`define MDS_ST_MAX_ERR 3
`define MDS_ST_LIM_ERR 4
`define MDS_ST_STATE 10:8
`define MDS_ST_ERR_MODE 11
`define MDS_ST_DONE_SEEN 12
// ==========================================================
// error codes reported in the error code register
`define MDS_ERR_TIME_LO 16'h7050
`define MDS_ERR_ENV_LO 16'h7051
`define MDS_ERR_EARLY 16'h7052
`define MDS_ERR_TIME_HI 16'h8350
`define MDS_ERR_ENV_HI 16'h8351
// ==========================================================
// reset values
`define MDS_RST_CTRL 32'h00000000
`define MDS_RST_VEL 16'h0000
`define MDS_RST_TTIME 32'hffffffff
// ==========================================================
// timing
`define MDS_CLK_KHZ 125000
`define MDS_DONE_LOW_MS 10
`define MDS_ENV_TICK_MS 1
`endif

// File: verif/mds_sva.sv
`default_nettype none
module mds_sva (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic [7:0] paddr, // byte address
	input wire logic pready, // ready
	input wire logic pslverr, // error response
	input wire logic drive_enable, // enable applied
	input wire logic safety_fault, // fault level
	input wire logic cmd_ignore, // host values ignored
	input wire logic brake_req, // braking
	input wire logic enable_withdraw, // enable removal
	input wire logic switch_pulse, // switch event
	input wire logic safe_stop // standstill error
);
	// ==========================================================
	// properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	a_ready_high: assert property (pready)
		else $error("ready low");
	a_slverr_bad: assert property (acc && (paddr > 8'h3c
		|| paddr[1:0] != 2'h0) |-> pslverr)
		else $error("no error response");
	a_slverr_good: assert property (acc && paddr <= 8'h3c
		&& paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error response on mapped word");
	a_switch_once: assert property (switch_pulse |=> !switch_pulse)
		else $error("switch pulse too long");
	a_switch_clean: assert property (switch_pulse |-> !cmd_ignore)
		else $error("switch during error braking");
	a_fault_ignore: assert property (safety_fault |-> ##[0:2] cmd_ignore)
		else $error("fault not taken");
	a_fault_brake: assert property ($rose(cmd_ignore) |-> ##[0:1] brake_req)
		else $error("no brake in error braking");
	a_withdraw_err: assert property (enable_withdraw |-> cmd_ignore)
		else $error("withdraw outside error");
	a_stop_drop: assert property ($rose(safe_stop) |->
		!$past(drive_enable) || !$past(drive_enable, 2))
		else $error("standstill with enable applied");
	a_stop_ignore: assert property (safe_stop |-> cmd_ignore)
		else $error("standstill takes host values");
endmodule // mds_sva
bind mds_supervisor mds_sva i_mds_sva (.*);
`default_nettype wire

// File: verif/mds_host_model.sv
`default_nettype none
module mds_host_model #(
	parameter VW = 16,
	parameter LOW = 104
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic [VW-1:0] tgt, // speed to settle at
	input wire logic [VW-1:0] skew_b, // extra speed on channel b
	input wire logic en_req, // keep drive enabled
	input wire logic done_req, // report completion
	input wire logic rush, // raise done without low time
	output logic [VW-1:0] vel_a, // speed, channel a
	output logic [VW-1:0] vel_b, // speed, channel b
	output logic drive_enable, // enable applied
	output logic transition_done // done to the device
);
	// ==========================================================
	// axis and host
	int low_cnt;
	assign vel_b = vel_a + skew_b;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vel_a <= '0;
			drive_enable <= 1'b0;
			transition_done <= 1'b0;
			low_cnt <= 0;
		end
		else
		begin
			// one unit a cycle: a real axis cannot jump
			vel_a <= (vel_a < tgt) ? vel_a + 1'b1 :
				(vel_a > tgt) ? vel_a - 1'b1 : vel_a;
			drive_enable <= en_req;
			low_cnt <= transition_done ? 0 : low_cnt + 1;
			transition_done <= done_req && (transition_done || rush
				|| low_cnt >= LOW);
		end
	end
endmodule // mds_host_model
`default_nettype wire

// File: verif/testbench.sv
`include "mds_consts.vh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// signals
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, cls, seed = 32'h9;
	logic pready, pslverr, drive_enable, transition_done, cmd_ignore;
	logic brake_req, enable_withdraw, switch_pulse, safe_stop;
	logic safety_fault = 0, en_req = 1, done_req = 0, rush = 0;
	logic [15:0] vel_a, vel_b, active_limit, tgt = 16'h0, skew_b = 16'h0;
	logic [63:0] notes[$];
	logic [63:0] nt;
	int n_errors = 0, checks_done = 0, sw_cnt = 0, base = 0;
	logic [31:0] imm_ctl[4] = '{32'h4, 32'h518, 32'h4, 32'h906};
	always #4 pclk = ~pclk;
	// tick must outlast the 33-cycle divider, or jerk mode never settles
	mds_supervisor #(.DONE_LOW_CYC(100), .ENV_TICK_CYC(40))
		i_mds_supervisor (.*);
	mds_host_model i_mds_host_model (.*);
	// ==========================================================
	// tasks
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("FAIL %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		notes.push_back({m, e});
		xfer(0, a, 32'h0);
	endtask
	task automatic rst();
		presetn <= 0;
		tick(5);
		presetn <= 1;
		tick(1);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================================
	// monitor: read data against the oldest note
	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
		begin
			nt = notes.pop_front();
			check(prdata & nt[63:32], nt[31:0]);
		end
		if (switch_pulse === 1'b1)
			sw_cnt++;
	end
	initial
	begin
		tick(40000);
		n_errors++;
		report_and_stop();
	end
	// ==========================================================
	// tests
	initial
	begin
		rst();
		rd(`MDS_REG_CTRL, '1, `MDS_RST_CTRL);
		rd(`MDS_REG_TTIME, '1, `MDS_RST_TTIME);
		rd(`MDS_REG_STATUS, '1, 32'h0);
		rd(8'h40, '1, 32'h0);
		$display("test registers done");
		for (int k = 0; k < 4; k++)
		begin
			rst();
			wr(`MDS_REG_SEL_WIN, 32'd100);
			tgt <= (k == 2) ? 16'd300 : 16'(xs() % 90 + 5);
			tick(310);
			base = sw_cnt;
			wr(`MDS_REG_CTRL, imm_ctl[k] | 32'h1);
			tick(4);
			check(sw_cnt - base, k < 2);
			if (k == 3)
			begin
				done_req <= 1;
				tick(8);
				check(sw_cnt - base, 1);
				rd(`MDS_REG_STATUS, 32'h5, 32'h0);
				done_req <= 0;
			end
			$display("test immediate %0d done", k);
		end
		for (int j = 0; j < 2; j++)
		begin
			rst();
			wr(`MDS_REG_SEL_WIN, 32'd100);
			wr(`MDS_REG_TOL, 32'd10);
			wr(`MDS_REG_JERK, (j == 0) ? 32'd8 : 32'd0);
			tgt <= 16'd400;
			tick(410);
			base = sw_cnt;
			wr(`MDS_REG_CTRL, 32'h1);
			// guard armed only now: at 400 in idle it would trip for real
			wr(`MDS_REG_GUARD_MAX, 32'h80000064);
			rd(`MDS_REG_ENVELOPE, 32'hffff, 32'd410);
			check(active_limit, 32'd410);
			wr(`MDS_REG_DECEL, 32'd16);
			en_req <= (j == 0);
			tgt <= 16'd0;
			tick(330);
			check(sw_cnt - base, j);
			repeat (1500) if (sw_cnt == base) @(posedge pclk);
			check(sw_cnt - base, 1);
			rd(`MDS_REG_STATUS, 32'h1f, 32'h0);
			en_req <= 1;
			$display("test ramp %0d done", j);
		end
		for (int c = 0; c < 3; c++)
		begin
			cls = (c == 0) ? 32'h0 : (c == 1) ? 32'h40 : 32'h20;
			rst();
			wr(`MDS_REG_TTIME, 32'd20);
			wr(`MDS_REG_SEL_WIN, 32'd10);
			wr(`MDS_REG_TOL, 32'd5);
			tgt <= 16'd100;
			tick(110);
			wr(`MDS_REG_CTRL, cls | 32'h1);
			tick(40);
			rd(`MDS_REG_ERRCODE, 32'hffff,
				c ? `MDS_ERR_TIME_HI : `MDS_ERR_TIME_LO);
			rd(`MDS_REG_STATUS, 32'h3, 32'h2);
			rst();
			wr(`MDS_REG_E_TOL, 32'd10);
			wr(`MDS_REG_STILL_WIN, 32'd5);
			wr(`MDS_REG_CTRL, cls);
			tgt <= 16'd100;
			tick(110);
			safety_fault <= 1;
			tick(4);
			check(cmd_ignore, 1);
			skew_b <= 16'd100;
			tick(4);
			rd(`MDS_REG_ERRCODE, 32'hffff,
				c ? `MDS_ERR_ENV_HI : `MDS_ERR_ENV_LO);
			rd(`MDS_REG_STATUS, 32'h801, 32'h801);
			safety_fault <= 0;
			skew_b <= 16'd0;
			tgt <= 16'd0;
			en_req <= 0;
			tick(120);
			rd(`MDS_REG_STATUS, 32'h700, 32'h300);
			wr(`MDS_REG_CTRL, cls | 32'h80);
			rd(`MDS_REG_STATUS, 32'h700, 32'h0);
			en_req <= 1;
			$display("test class %0d done", c);
		end
		rst();
		wr(`MDS_REG_SEL_WIN, 32'd10);
		wr(`MDS_REG_TOL, 32'd5);
		tgt <= 16'd100;
		tick(110);
		done_req <= 1;
		tick(4);
		done_req <= 0;
		tick(20);
		// the idle edge above was a valid one: clear it before the rush
		wr(`MDS_REG_STATUS, 32'h1000);
		wr(`MDS_REG_CTRL, 32'h3);
		rush <= 1;
		done_req <= 1;
		tick(3);
		rush <= 0;
		done_req <= 0;
		tick(3);
		rd(`MDS_REG_STATUS, 32'h1004, 32'h0);
		done_req <= 1;
		tick(130);
		rd(`MDS_REG_STATUS, 32'h1804, 32'h1804);
		rd(`MDS_REG_ERRCODE, 32'hffff, `MDS_ERR_EARLY);
		$display("test done edge done");
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
